// ==== design/flcr_defines.vh ====
// constants for the fault line channel response block
`ifndef FLCR_DEFINES_VH
`define FLCR_DEFINES_VH

// response register indices on the register port
`define FLCR_IDX_Z0_LINE_A 2'h0
`define FLCR_IDX_Z0_LINE_B 2'h1
`define FLCR_IDX_Z1_LINE_A 2'h2
`define FLCR_IDX_Z1_LINE_B 2'h3

// response register field layout
`define FLCR_RESP_CHAN_LSB 0
`define FLCR_RESP_CHAN_MSB 3
`define FLCR_RESP_RSVD_VAL 4'h0
`define FLCR_RESP_RESET 4'h0

// reset values of the status, alert, read data and chan_on outputs
`define FLCR_RD_DATA_RESET 8'h00
`define FLCR_STATUS_RESET 4'h0
`define FLCR_ALERT_N_RESET 1'b1
`define FLCR_CHAN_ON_RESET 1'b1

// released fault line level
`define FLCR_LINE_IDLE 1'b1

// persistence time before a shutdown is taken
`define FLCR_CLK_PERIOD_NS 10
`define FLCR_PERSIST_NS 10000
`define FLCR_PERSIST_CYCLES ((`FLCR_PERSIST_NS + `FLCR_CLK_PERIOD_NS - 1) / `FLCR_CLK_PERIOD_NS)

// width of the turn-on delay and rise counts
`define FLCR_TIME_W 16

`endif

// ==== design/flcr_line_filter.v ====
// fault line synchroniser, assertion detector and persistence timer
`timescale 1ns/10ps
`include "flcr_defines.vh"

module flcr_line_filter #(
  parameter CNT_W = 11,
  parameter [CNT_W-1:0] PERSIST_CYCLES = `FLCR_PERSIST_CYCLES
) (
  input wire clk,
  input wire rst_b,
  input wire line_in,
  output wire asserted,
  output wire assert_pulse,
  output wire persisted
);

  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg level_reg;
  reg asserted_reg;
  reg pulse_reg;
  reg persist_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg level_next;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= `FLCR_LINE_IDLE;
      sync2_reg <= `FLCR_LINE_IDLE;
      sync3_reg <= `FLCR_LINE_IDLE;
    end else begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // level moves only when the last two stages agree
  always @* begin
    level_next = level_reg;
    if (sync2_reg == sync3_reg) begin
      level_next = sync2_reg;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_reg <= `FLCR_LINE_IDLE;
      asserted_reg <= 1'b0;
      pulse_reg <= 1'b0;
      persist_reg <= 1'b0;
      cnt_reg <= {CNT_W{1'b0}};
    end else begin
      level_reg <= level_next;
      // R11 low level
      asserted_reg <= ~level_next;
      pulse_reg <= ~level_next & ~asserted_reg;
      if (level_next) begin
        cnt_reg <= {CNT_W{1'b0}};
        persist_reg <= 1'b0;
      end else if (cnt_reg != PERSIST_CYCLES) begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        // R9 still low after
        persist_reg <= (cnt_reg == PERSIST_CYCLES - {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

  assign asserted = asserted_reg;
  assign assert_pulse = pulse_reg;
  assign persisted = persist_reg;

endmodule

// ==== design/flcr_top.v ====
// fault line channel response: registers, status, alert and per-channel shutdown/restart
// Functional notes
// R1 - The fault lines are watched as inputs while the device may drive them (here oe stays 0), and each line's own response register picks the reaction.
// R2 - In zone 0 the two line registers steer channels 0 to 3, bit k for channel k.
// R3 - The second zone-0 line has its own register of the same layout over channels 0 to 3, evaluated on its own.
// R4 - In zone 1 the first line register steers channels 4 to 7, bits 0 to 3 in order.
// R5 - The second zone-1 line has its own register of the same layout over channels 4 to 7.
// R6 - An assertion of a line whose register has any bit set drives the alert low and sets that line's status bit.
// R7 - Bits 7 to 4 of every response register are read-only and read as zero.
// R8 - A channel whose response bit is 0 is never disturbed by that line.
// R9 - A channel whose response bit is 1 is shut down only if the line is still low 10 us after it went low.
// R10 - After such a shutdown, when the line releases, the channel restarts through its turn-on delay then its rise time.
// R11 - A line counts as asserted while it is low, and any device on it may pull it low.
// R12 - A channel enabled on both lines of its zone stays down while either enabled line holds and restarts only when none does.
`timescale 1ns/10ps
`include "flcr_defines.vh"

module flcr_top #(
  parameter NCHAN = 8,
  parameter TW = `FLCR_TIME_W,
  parameter PERSIST_CYCLES = `FLCR_PERSIST_CYCLES
) (
  input wire clk,
  input wire rst_b,
  input wire zone0_fault_line_a_in,
  output wire zone0_fault_line_a_out,
  output wire zone0_fault_line_a_oe,
  input wire zone0_fault_line_b_in,
  output wire zone0_fault_line_b_out,
  output wire zone0_fault_line_b_oe,
  input wire zone1_fault_line_a_in,
  output wire zone1_fault_line_a_out,
  output wire zone1_fault_line_a_oe,
  input wire zone1_fault_line_b_in,
  output wire zone1_fault_line_b_out,
  output wire zone1_fault_line_b_oe,
  input wire [1:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  output wire [7:0] reg_rd_data,
  input wire [3:0] status_clear,
  output wire [3:0] status_mfr_bits,
  output wire alert_out_n,
  input wire [NCHAN*TW-1:0] ton_delay_cycles,
  input wire [NCHAN*TW-1:0] ton_rise_cycles,
  output wire [NCHAN-1:0] chan_on,
  output wire [NCHAN-1:0] chan_rising,
  output wire [NCHAN-1:0] chan_fault_off
);

  localparam ST_RUN = 2'b00;
  localparam ST_OFF = 2'b01;
  localparam ST_DELAY = 2'b10;
  localparam ST_RISE = 2'b11;
  localparam [TW-1:0] ONE = {{(TW-1){1'b0}}, 1'b1};
  // persistence counter width, wide enough for the default 10 us
  localparam PCNT_W = 11;

  reg [3:0] zone0_line_a_response_reg;
  reg [3:0] zone0_line_b_response_reg;
  reg [3:0] zone1_line_a_response_reg;
  reg [3:0] zone1_line_b_response_reg;
  reg [7:0] rd_data_reg;
  reg [7:0] rd_data_next;
  reg [3:0] status_reg;
  reg alert_n_reg;
  reg [3:0] line_oe_reg;
  reg [3:0] line_out_reg;

  wire [3:0] line_pin;
  wire [3:0] line_asserted;
  wire [3:0] line_pulse;
  wire [3:0] line_persist;
  wire [15:0] resp_flat;
  wire [3:0] line_armed;
  wire [3:0] status_next;
  wire [3:0] wr_sel;
  wire [3:0] wr_chan;
  wire alert_n_next;

  assign line_pin = {zone1_fault_line_b_in, zone1_fault_line_a_in, zone0_fault_line_b_in, zone0_fault_line_a_in};

  // R1 one watcher per line
  genvar li;
  generate
    for (li = 0; li < 4; li = li + 1) begin : g_line
      flcr_line_filter #(
        .CNT_W(PCNT_W),
        .PERSIST_CYCLES(PERSIST_CYCLES[PCNT_W-1:0])
      ) u_filt (
        .clk(clk),
        .rst_b(rst_b),
        .line_in(line_pin[li]),
        .asserted(line_asserted[li]),
        .assert_pulse(line_pulse[li]),
        .persisted(line_persist[li])
      );
      assign line_armed[li] = |resp_flat[li*4 +: 4];
    end
  endgenerate

  assign resp_flat = {zone1_line_b_response_reg, zone1_line_a_response_reg,
                      zone0_line_b_response_reg, zone0_line_a_response_reg};

  // one write strobe per response register
  assign wr_sel[0] = reg_wr_en & (reg_addr == `FLCR_IDX_Z0_LINE_A);
  assign wr_sel[1] = reg_wr_en & (reg_addr == `FLCR_IDX_Z0_LINE_B);
  assign wr_sel[2] = reg_wr_en & (reg_addr == `FLCR_IDX_Z1_LINE_A);
  assign wr_sel[3] = reg_wr_en & (reg_addr == `FLCR_IDX_Z1_LINE_B);
  // R7 writes to the upper bits are dropped
  assign wr_chan = reg_wr_data[`FLCR_RESP_CHAN_MSB:`FLCR_RESP_CHAN_LSB];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zone0_line_a_response_reg <= `FLCR_RESP_RESET;
      zone0_line_b_response_reg <= `FLCR_RESP_RESET;
      zone1_line_a_response_reg <= `FLCR_RESP_RESET;
      zone1_line_b_response_reg <= `FLCR_RESP_RESET;
    end else begin
      if (wr_sel[0]) begin
        zone0_line_a_response_reg <= wr_chan;
      end
      if (wr_sel[1]) begin
        zone0_line_b_response_reg <= wr_chan;
      end
      if (wr_sel[2]) begin
        zone1_line_a_response_reg <= wr_chan;
      end
      if (wr_sel[3]) begin
        zone1_line_b_response_reg <= wr_chan;
      end
    end
  end

  // R7 upper bits read zero
  always @* begin
    rd_data_next = `FLCR_RD_DATA_RESET;
    case (reg_addr)
      `FLCR_IDX_Z0_LINE_A: begin
        rd_data_next = {`FLCR_RESP_RSVD_VAL, zone0_line_a_response_reg};
      end
      `FLCR_IDX_Z0_LINE_B: begin
        rd_data_next = {`FLCR_RESP_RSVD_VAL, zone0_line_b_response_reg};
      end
      `FLCR_IDX_Z1_LINE_A: begin
        rd_data_next = {`FLCR_RESP_RSVD_VAL, zone1_line_a_response_reg};
      end
      default: begin
        rd_data_next = {`FLCR_RESP_RSVD_VAL, zone1_line_b_response_reg};
      end
    endcase
  end

  // R6 sticky status, set beats clear
  assign status_next = (status_reg & ~status_clear) | (line_pulse & line_armed);
  // alert stays low while any status bit is held
  assign alert_n_next = ~|status_next;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= `FLCR_RD_DATA_RESET;
      status_reg <= `FLCR_STATUS_RESET;
      alert_n_reg <= `FLCR_ALERT_N_RESET;
      line_oe_reg <= 4'h0;
      line_out_reg <= 4'h0;
    end else begin
      rd_data_reg <= rd_data_next;
      status_reg <= status_next;
      // R6 alert low while any status set
      alert_n_reg <= alert_n_next;
      // lines are only monitored here; pulling them is another block's job
      line_oe_reg <= 4'h0;
      line_out_reg <= 4'h0;
    end
  end

  // per-channel shutdown and restart sequencer
  genvar ci;
  generate
    for (ci = 0; ci < NCHAN; ci = ci + 1) begin : g_chan
      localparam ZL = (ci / 4) * 2;
      localparam BK = ci % 4;
      reg [1:0] st_reg;
      reg [1:0] st_next;
      reg [TW-1:0] cnt_reg;
      reg [TW-1:0] cnt_next;
      reg on_reg;
      reg rise_reg;
      reg off_reg;
      wire en_a;
      wire en_b;
      wire kill;
      wire hold;
      reg on_next;
      reg rise_next;
      reg off_next;

      // R2 R3 R4 R5 bit k of each zone line register
      assign en_a = resp_flat[ZL*4 + BK];
      assign en_b = resp_flat[(ZL+1)*4 + BK];
      // R8 R9 only enabled lines, only after persistence
      assign kill = (en_a & line_persist[ZL]) | (en_b & line_persist[ZL+1]);
      // R12 either enabled line still low keeps it down
      assign hold = (en_a & line_asserted[ZL]) | (en_b & line_asserted[ZL+1]);

      always @* begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
          ST_RUN: begin
            if (kill) begin
              st_next = ST_OFF;
            end
          end
          ST_OFF: begin
            // R10 restart with turn-on delay
            if (!hold) begin
              st_next = ST_DELAY;
              cnt_next = ton_delay_cycles[ci*TW +: TW];
            end
          end
          ST_DELAY: begin
            // a new persistent fault aborts the restart
            if (kill) begin
              st_next = ST_OFF;
            end else if (cnt_reg == {TW{1'b0}}) begin
              st_next = ST_RISE;
              cnt_next = ton_rise_cycles[ci*TW +: TW];
            end else begin
              cnt_next = cnt_reg - ONE;
            end
          end
          ST_RISE: begin
            // R10 then the rise time
            if (kill) begin
              st_next = ST_OFF;
            end else if (cnt_reg == {TW{1'b0}}) begin
              st_next = ST_RUN;
            end else begin
              cnt_next = cnt_reg - ONE;
            end
          end
          default: begin
            st_next = ST_RUN;
          end
        endcase
      end

      // output levels decoded from the state being entered
      always @* begin
        on_next = 1'b0;
        rise_next = 1'b0;
        off_next = 1'b0;
        case (st_next)
          ST_RUN: begin
            on_next = 1'b1;
          end
          ST_RISE: begin
            on_next = 1'b1;
            rise_next = 1'b1;
          end
          ST_OFF: begin
            off_next = 1'b1;
          end
          default: begin
            on_next = 1'b0;
          end
        endcase
      end

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          st_reg <= ST_RUN;
          cnt_reg <= {TW{1'b0}};
          on_reg <= `FLCR_CHAN_ON_RESET;
          rise_reg <= 1'b0;
          off_reg <= 1'b0;
        end else begin
          st_reg <= st_next;
          cnt_reg <= cnt_next;
          on_reg <= on_next;
          rise_reg <= rise_next;
          off_reg <= off_next;
        end
      end

      assign chan_on[ci] = on_reg;
      assign chan_rising[ci] = rise_reg;
      assign chan_fault_off[ci] = off_reg;
    end
  endgenerate

  assign reg_rd_data = rd_data_reg;
  assign status_mfr_bits = status_reg;
  assign alert_out_n = alert_n_reg;
  assign zone0_fault_line_a_out = line_out_reg[0];
  assign zone0_fault_line_b_out = line_out_reg[1];
  assign zone1_fault_line_a_out = line_out_reg[2];
  assign zone1_fault_line_b_out = line_out_reg[3];
  assign zone0_fault_line_a_oe = line_oe_reg[0];
  assign zone0_fault_line_b_oe = line_oe_reg[1];
  assign zone1_fault_line_a_oe = line_oe_reg[2];
  assign zone1_fault_line_b_oe = line_oe_reg[3];

endmodule

// ==== test/flcr_sva.sv ====
// assertion checker for the fault line channel response block
`timescale 1ns/10ps
module flcr_sva #(
  parameter NCHAN = 8,
  parameter PERSIST_CYCLES = 1000
) (
  input wire clk,
  input wire rst_b,
  input wire zone0_fault_line_a_in,
  input wire zone0_fault_line_b_in,
  input wire zone1_fault_line_a_in,
  input wire zone1_fault_line_b_in,
  input wire [1:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data,
  input wire [3:0] status_mfr_bits,
  input wire alert_out_n,
  input wire [NCHAN-1:0] chan_on,
  input wire [NCHAN-1:0] chan_rising,
  input wire [NCHAN-1:0] chan_fault_off
);
  wire [3:0] ln = {zone1_fault_line_b_in, zone1_fault_line_a_in, zone0_fault_line_b_in, zone0_fault_line_a_in};
  reg [15:0] z0_low;
  reg [15:0] z1_low;
  // consecutive cycles with some line of the zone low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      z0_low <= 16'h0000;
      z1_low <= 16'h0000;
    end else begin
      z0_low <= (ln[0] & ln[1]) ? 16'h0000 : z0_low + 16'h0001;
      z1_low <= (ln[2] & ln[3]) ? 16'h0000 : z1_low + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rsvd_read_zero: assert property (reg_rd_data[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  a_write_readback: assert property (reg_wr_en ##1 (!reg_wr_en && $stable(reg_addr)) |=>
    reg_rd_data == ($past(reg_wr_data, 2) & 8'h0F)) else $error("readback mismatch");
  a_alert_follows: assert property (alert_out_n == !(|status_mfr_bits))
    else $error("alert does not follow status");
  a_status_cause: assert property (((status_mfr_bits & ~$past(status_mfr_bits)) & $past(ln, 2)) == 4'h0)
    else $error("status set without low line");
  a_off_not_on: assert property ((chan_fault_off & chan_on) == 0)
    else $error("channel on while held off");
  a_rise_is_on: assert property ((chan_rising & ~chan_on) == 0)
    else $error("rising while off");
  a_on_via_rise: assert property (((chan_on & ~$past(chan_on)) & ~chan_rising) == 0)
    else $error("channel on without rise");
  a_persist_z0: assert property (|((chan_fault_off & ~$past(chan_fault_off)) & 8'h0F) |-> z0_low >= PERSIST_CYCLES)
    else $error("zone 0 shutdown too early");
  a_persist_z1: assert property (|((chan_fault_off & ~$past(chan_fault_off)) & 8'hF0) |-> z1_low >= PERSIST_CYCLES)
    else $error("zone 1 shutdown too early");
  c_alert: cover property (!alert_out_n);
  c_shutdown: cover property (|chan_fault_off);
  c_rising: cover property (|chan_rising);
endmodule

bind flcr_top flcr_sva #(.NCHAN(NCHAN), .PERSIST_CYCLES(PERSIST_CYCLES)) u_sva (
  .clk, .rst_b, .zone0_fault_line_a_in, .zone0_fault_line_b_in, .zone1_fault_line_a_in,
  .zone1_fault_line_b_in, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_data,
  .status_mfr_bits, .alert_out_n, .chan_on, .chan_rising, .chan_fault_off);

// ==== test/flcr_partner.sv ====
// other supervisors sharing the wired fault lines
`timescale 1ns/10ps
module flcr_partner (
  input wire [3:0] pull,
  input wire [3:0] dev_oe,
  input wire [3:0] dev_out,
  output wire [3:0] line
);
  assign line = ~(pull | (dev_oe & ~dev_out));
endmodule

// ==== test/flcr_top_test.sv ====
// self-checking bench for the fault line channel response block
`timescale 1ns/10ps
module flcr_top_test;
  localparam PC = 20;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [1:0] ra = 2'h0;
  reg we = 1'b0;
  reg [7:0] wd = 8'h00;
  reg [3:0] sclr = 4'h0;
  reg [3:0] pull = 4'h0;
  reg [127:0] tdel = 128'h0;
  reg [127:0] trise = 128'h0;
  wire [3:0] line, lo, oe, st;
  wire [7:0] rd, con, cri, coff;
  wire alert_n;
  integer fail_count = 0;
  integer tests_run = 0;
  integer i, k, m;
  reg [7:0] d;
  initial begin
    forever #5 clk = ~clk;
  end
  flcr_partner far (.pull(pull), .dev_oe(oe), .dev_out(lo), .line(line));
  flcr_top #(.PERSIST_CYCLES(PC)) uut (.clk(clk), .rst_b(rst_b),
    .zone0_fault_line_a_in(line[0]), .zone0_fault_line_a_out(lo[0]), .zone0_fault_line_a_oe(oe[0]),
    .zone0_fault_line_b_in(line[1]), .zone0_fault_line_b_out(lo[1]), .zone0_fault_line_b_oe(oe[1]),
    .zone1_fault_line_a_in(line[2]), .zone1_fault_line_a_out(lo[2]), .zone1_fault_line_a_oe(oe[2]),
    .zone1_fault_line_b_in(line[3]), .zone1_fault_line_b_out(lo[3]), .zone1_fault_line_b_oe(oe[3]),
    .reg_addr(ra), .reg_wr_en(we), .reg_wr_data(wd), .reg_rd_data(rd), .status_clear(sclr),
    .status_mfr_bits(st), .alert_out_n(alert_n), .ton_delay_cycles(tdel), .ton_rise_cycles(trise),
    .chan_on(con), .chan_rising(cri), .chan_fault_off(coff));
  task chk(input [23:0] got, input [23:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [1:0] a, input [7:0] v);
    begin
      ra <= a;
      wd <= v;
      we <= 1'b1;
      cyc(1);
      we <= 1'b0;
      cyc(1);
    end
  endtask
  // channels in msk go through delay then rise, the rest stay on
  function [15:0] exp_seq(input integer k, input [7:0] msk);
    integer c, dl, rs;
    begin
      exp_seq = 16'h00FF;
      for (c = 0; c < 8; c = c + 1) begin
        dl = tdel[c*16+:16];
        rs = trise[c*16+:16];
        if (msk[c]) begin
          exp_seq[c] = k > dl;
          exp_seq[8+c] = k > dl && k <= dl + rs + 1;
        end
      end
    end
  endfunction
  task restart(input [7:0] msk);
    begin
      k = 0;
      while ((coff & msk) !== 8'h00 && k < 50) begin
        cyc(1);
        k = k + 1;
      end
      for (k = 0; k < 24; k = k + 1) begin
        chk({cri, con}, exp_seq(k, msk));
        cyc(1);
      end
    end
  endtask
  task clr_status;
    begin
      sclr <= 4'hF;
      cyc(1);
      sclr <= 4'h0;
      cyc(2);
      chk({st, alert_n}, 5'h01);
    end
  endtask
  task test_done;
    begin
      if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    fail_count = fail_count + 1;
    $display("CHECK FAILED %0t watchdog expired", $time);
    test_done;
  end
  initial begin
    i = $urandom(56);
    for (i = 0; i < 8; i = i + 1) begin
      tdel[i*16+:16] <= $urandom % 8;
      trise[i*16+:16] <= $urandom % 8;
    end
    cyc(12);
    rst_b <= 1'b1;
    cyc(1);
    pull <= 4'hF;
    cyc(PC + 12);
    chk({st, alert_n, con, coff}, 21'h01FF00);
    pull <= 4'h0;
    cyc(8);
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      wr(i[1:0], d);
      cyc(1);
      chk(rd, {4'h0, d[3:0]});
      wr(i[1:0], 8'hF0);
      cyc(1);
      chk(rd, 8'h00);
    end
    for (i = 0; i < 4; i = i + 1) begin
      m = 1 + $urandom % 15;
      wr(i[1:0], {4'h0, m[3:0]});
      pull[i] <= 1'b1;
      cyc(PC / 2);
      pull[i] <= 1'b0;
      cyc(PC);
      chk(coff, 8'h00);
      pull[i] <= 1'b1;
      cyc(PC + 12);
      d = (i < 2) ? {4'h0, m[3:0]} : {m[3:0], 4'h0};
      chk({st, alert_n}, {4'h1 << i, 1'b0});
      chk({oe, lo}, 8'h00);
      chk({con, coff}, {~d, d});
      pull[i] <= 1'b0;
      restart(d);
      clr_status;
      wr(i[1:0], 8'h00);
    end
    wr(2'h2, 8'h08);
    wr(2'h3, 8'h08);
    pull[2] <= 1'b1;
    cyc(5);
    pull[3] <= 1'b1;
    cyc(PC + 12);
    pull[2] <= 1'b0;
    cyc(PC);
    chk({con, coff}, 16'h7F80);
    sclr <= 4'h4;
    cyc(1);
    sclr <= 4'h0;
    cyc(2);
    chk({st, alert_n}, {4'h8, 1'b0});
    pull[3] <= 1'b0;
    restart(8'h80);
    clr_status;
    test_done;
  end
endmodule
